// ---- logic/mdm_master.sv ----
/*
 * Multidrop master station: buffer memory, handshake flags, station scan.
 * Assumes a classic Wishbone master and a link that answers each byte
 * request with a one-cycle ack while the request stands.
 */
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module mdm_master #(
	parameter int STATIONS      = mdm_pkg::MDM_STATIONS,
	parameter int BYTES_PER_STN = mdm_pkg::MDM_BYTES_PER_STN,
	parameter int WDT_CYCLES    = mdm_pkg::MDM_WDT_CYCLES
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [8:2]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	output mdm_pkg::mdm_link_req_s     link_req_o,
	input  wire mdm_pkg::mdm_link_rsp_s link_rsp_i,
	output logic                       transfer_active_flag_o,
	output logic                       setup_error_flag_o,
	output logic                       scan_error_flag_o,
	output logic                       watchdog_fault_flag_o
);
	import mdm_pkg::*;

	localparam logic [2:0] LAST_STN = 3'(STATIONS - 1);
	localparam logic [3:0] LAST_BYT = 4'(BYTES_PER_STN - 1);

	// ****************************************************************
	// Storage and index arithmetic
	// ****************************************************************
	logic [MDM_DW-1:0] mem [0:(1<<MDM_AW)-1];
	mdm_state_s        q;
	mdm_state_s        d;
	logic              wdt_exp;
	logic              bus_req;
	logic              bus_wr_buf;
	logic              link_wr;
	logic [6:0]        span;
	logic [6:0]        rx_idx;
	logic [6:0]        tx_idx;
	logic [7:0]        tx_rd;

	// Ascending station order, fixed span per station
	assign span   = 7'(int'(q.stn) * BYTES_PER_STN
		+ int'(q.byt));
	assign rx_idx = MDM_RX_BASE + span;
	assign tx_idx = MDM_TX_BASE + span;
	assign tx_rd  = mem[tx_idx];

	assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
	// Receive area and handshake words are not buffer-writable by software
	assign bus_wr_buf = bus_req && wb_we_i && wb_sel_i[0]
		&& !(wb_adr_i >= MDM_RX_BASE && wb_adr_i <= MDM_RX_LAST)
		&& wb_adr_i != MDM_CTRL_IDX && wb_adr_i != MDM_STAT_IDX;
	assign link_wr = q.st == ST_SCAN_WAIT && link_rsp_i.ack
		&& !link_rsp_i.err;

	mdm_wdog #(
		.CYCLES   (WDT_CYCLES)
	) u_wdog (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.ce_i     (ce_i),
		.arm_i    ((q.st == ST_SETUP_WAIT || q.st == ST_SCAN_WAIT)
			&& !link_rsp_i.ack),
		.expire_o (wdt_exp)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		d = q;
		d.ack = 1'b0;
		// Bus slave: one wait state, every other index reads its buffer byte
		if (bus_req) begin
			d.ack = 1'b1;
			d.dat = '0;
			if (wb_we_i) begin
				// Low sixteen bits of the control word are ignored
				if (wb_adr_i == MDM_CTRL_IDX && wb_sel_i[2]) begin
					d.run = wb_dat_i[MDM_CTRL_RUN_BIT];
					d.clr = wb_dat_i[MDM_CTRL_CLR_BIT];
				end
			end else if (wb_adr_i == MDM_CTRL_IDX) begin
				d.dat[MDM_CTRL_RUN_BIT] = q.run;
				d.dat[MDM_CTRL_CLR_BIT] = q.clr;
			end else if (wb_adr_i == MDM_STAT_IDX) begin
				// Reserved positions read zero
				d.dat[MDM_STAT_ACTIVE_BIT] = q.active;
				d.dat[MDM_STAT_SETUP_BIT]  = q.setup_err;
				d.dat[MDM_STAT_SCAN_BIT]   = q.scan_err;
				d.dat[MDM_STAT_WDT_BIT]    = q.wdt_flag;
			end else begin
				d.dat[7:0] = mem[wb_adr_i];
			end
		end

		// Clear first so that a new fault in the same cycle wins
		if (q.clr) begin
			d.setup_err = 1'b0;
			d.scan_err  = 1'b0;
		end
		if (wdt_exp) begin
			d.wdt_flag = 1'b1;
		end

		case (q.st)
			ST_IDLE: begin
				d.link.req = 1'b0;
				if (q.run && !q.setup_err && !q.scan_err) begin
					d.st  = ST_SETUP_REQ;
					d.stn = '0;
					d.byt = '0;
				end
			end
			ST_SETUP_REQ: begin
				d.link.req     = 1'b1;
				d.link.setup   = 1'b1;
				d.link.station = q.stn;
				d.link.tx      = '0;
				d.st           = ST_SETUP_WAIT;
			end
			ST_SETUP_WAIT: begin
				if (link_rsp_i.ack) begin
					d.link.req = 1'b0;
					if (link_rsp_i.err) begin
						d.setup_err = 1'b1;
						d.st        = ST_HALT;
					end else if (q.stn == LAST_STN) begin
						d.stn = '0;
						d.byt = '0;
						d.st  = ST_SCAN_REQ;
					end else begin
						d.stn = q.stn + 3'h1;
						d.st  = ST_SETUP_REQ;
					end
				end else if (wdt_exp) begin
					d.link.req  = 1'b0;
					d.setup_err = 1'b1;
					d.st        = ST_HALT;
				end
			end
			ST_SCAN_REQ: begin
				// Transmit word low byte goes out bit for bit
				d.link.req     = 1'b1;
				d.link.setup   = 1'b0;
				d.link.station = q.stn;
				d.link.tx      = tx_rd;
				d.st           = ST_SCAN_WAIT;
			end
			ST_SCAN_WAIT: begin
				if (link_rsp_i.ack) begin
					d.link.req = 1'b0;
					if (link_rsp_i.err) begin
						d.scan_err = 1'b1;
						d.st       = ST_HALT;
					end else begin
						d.st = ST_SCAN_REQ;
						if (q.byt != LAST_BYT) begin
							d.byt = q.byt + 4'h1;
						end else begin
							d.byt = '0;
							d.stn = (q.stn == LAST_STN) ? 3'h0
								: q.stn + 3'h1;
						end
					end
				end else if (wdt_exp) begin
					d.link.req = 1'b0;
					d.scan_err = 1'b1;
					d.st       = ST_HALT;
				end
			end
			ST_HALT: begin
				d.link.req = 1'b0;
				if (!d.setup_err && !d.scan_err) begin
					d.st = ST_IDLE;
				end
			end
			default: begin
				d.st       = ST_IDLE;
				d.link.req = 1'b0;
			end
		endcase

		// Dropping the run request stops the link at once
		if (!q.run) begin
			d.st       = ST_IDLE;
			d.link.req = 1'b0;
		end

		// Setup and scan errors held until the clear request, not until they vanish
		d.active = (d.st == ST_SCAN_REQ || d.st == ST_SCAN_WAIT)
			&& !d.setup_err && !d.scan_err;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q    <= '0;
			q.st <= ST_IDLE;
		end else if (ce_i) begin
			q <= d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (bus_wr_buf) begin
				mem[wb_adr_i] <= wb_dat_i[7:0];
			end
			if (link_wr) begin
				// Input points land bit for bit in the receive word
				mem[rx_idx] <= link_rsp_i.rx;
			end
		end
	end

	assign wb_dat_o               = q.dat;
	assign wb_ack_o               = q.ack;
	assign link_req_o             = q.link;
	assign transfer_active_flag_o = q.active;
	assign setup_error_flag_o     = q.setup_err;
	assign scan_error_flag_o      = q.scan_err;
	assign watchdog_fault_flag_o  = q.wdt_flag;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [6:0] rx_idx_q;
	logic [7:0] rx_val_q;
	logic       rx_chk_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_chk_q <= 1'b0;
			rx_idx_q <= '0;
			rx_val_q <= '0;
		end else if (ce_i) begin
			rx_chk_q <= link_wr;
			rx_idx_q <= rx_idx;
			rx_val_q <= link_rsp_i.rx;
		end
	end

	property p_tx_map;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && q.st == ST_SCAN_REQ && q.run
			|=> link_req_o.tx == $past(tx_rd);
	endproperty
	a_tx_map: assert property (p_tx_map)
		else $error("transmit byte differs from buffer word");

	property p_tx_hold;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && link_req_o.req && !link_req_o.setup && !link_rsp_i.ack
			&& q.run |=> $stable(link_req_o.tx);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("transmit byte changed before answer");

	property p_rx_map;
		@(posedge clk_i) disable iff (rst_i)
		rx_chk_q |-> mem[rx_idx_q] == rx_val_q;
	endproperty
	a_rx_map: assert property (p_rx_map)
		else $error("received byte not stored");

	property p_rx_area;
		@(posedge clk_i) disable iff (rst_i)
		link_wr |-> rx_idx >= MDM_RX_BASE && rx_idx <= MDM_RX_LAST
			&& tx_idx >= MDM_TX_BASE && tx_idx <= MDM_TX_LAST;
	endproperty
	a_rx_area: assert property (p_rx_area)
		else $error("link data outside its buffer area");

	property p_active_on;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && q.st == ST_SCAN_WAIT && !link_rsp_i.ack && !wdt_exp
			&& q.run && !q.setup_err && !q.scan_err
			|=> transfer_active_flag_o;
	endproperty
	a_active_on: assert property (p_active_on)
		else $error("transfer flag off during scan");

	property p_active_off;
		@(posedge clk_i) disable iff (rst_i)
		q.st == ST_SETUP_WAIT || setup_error_flag_o || scan_error_flag_o
			|-> !transfer_active_flag_o;
	endproperty
	a_active_off: assert property (p_active_off)
		else $error("transfer flag on in setup or error");

	property p_err_set;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && q.st == ST_SCAN_WAIT && link_rsp_i.ack && link_rsp_i.err
			&& q.run |=> scan_error_flag_o ##1 !transfer_active_flag_o;
	endproperty
	a_err_set: assert property (p_err_set)
		else $error("scan error not flagged");

	property p_err_hold;
		@(posedge clk_i) disable iff (rst_i)
		setup_error_flag_o && !q.clr |=> setup_error_flag_o;
	endproperty
	a_err_hold: assert property (p_err_hold)
		else $error("setup error dropped without clear");

	property p_stop;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !q.run |=> !link_req_o.req && q.st == ST_IDLE;
	endproperty
	a_stop: assert property (p_stop)
		else $error("link still running after run dropped");

	property p_wdt;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && wdt_exp |=> watchdog_fault_flag_o [*2];
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog flag not raised");

	property p_order;
		@(posedge clk_i) disable iff (rst_i)
		$changed(link_req_o.station) && !link_req_o.setup && q.run
			|-> link_req_o.station == $past(link_req_o.station) + 3'h1
			|| link_req_o.station == 3'h0;
	endproperty
	a_order: assert property (p_order)
		else $error("stations not served in ascending order");

	c_scan: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(transfer_active_flag_o));
	c_setup_err: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(setup_error_flag_o));
	c_clear: cover property (@(posedge clk_i) disable iff (rst_i)
		$fell(scan_error_flag_o));
	c_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
		link_wr && q.stn == LAST_STN && q.byt == LAST_BYT);

endmodule : mdm_master

// ---- common/mdm_pkg.sv ----
/*
 * Constants, layouts and types of the multidrop master I/O mapping block.
 * Assumes one 50 MHz module clock and a word-addressed Wishbone slave port.
 */
package mdm_pkg;

	// ****************************************************************
	// Buffer map
	// ****************************************************************
	localparam int            MDM_AW        = 7;
	localparam int            MDM_DW        = 8;
	localparam logic [6:0]    MDM_RX_BASE   = 7'h20;
	localparam logic [6:0]    MDM_RX_LAST   = 7'h3F;
	localparam logic [6:0]    MDM_TX_BASE   = 7'h40;
	localparam logic [6:0]    MDM_TX_LAST   = 7'h5F;
	localparam logic [6:0]    MDM_CTRL_IDX  = 7'h70;
	localparam logic [6:0]    MDM_STAT_IDX  = 7'h71;

	// ****************************************************************
	// Handshake bit positions
	// ****************************************************************
	localparam int            MDM_STAT_ACTIVE_BIT = 0;
	localparam int            MDM_STAT_SETUP_BIT  = 1;
	localparam int            MDM_STAT_SCAN_BIT   = 2;
	localparam int            MDM_STAT_WDT_BIT    = 13;
	localparam int            MDM_CTRL_RUN_BIT    = 16;
	localparam int            MDM_CTRL_CLR_BIT    = 17;

	// ****************************************************************
	// Station layout and timing
	// ****************************************************************
	localparam int            MDM_STATIONS      = 8;
	localparam int            MDM_BYTES_PER_STN = 2;
	localparam int            MDM_CLK_MHZ       = 50;
	localparam int            MDM_WDT_TIME_US   = 10000;
	localparam int            MDM_WDT_CYCLES    = MDM_WDT_TIME_US * MDM_CLK_MHZ;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP_REQ,
		ST_SETUP_WAIT,
		ST_SCAN_REQ,
		ST_SCAN_WAIT,
		ST_HALT
	} mdm_state_e;

	typedef struct packed {
		logic        req;
		logic        setup;
		logic [2:0]  station;
		logic [7:0]  tx;
	} mdm_link_req_s;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [7:0]  rx;
	} mdm_link_rsp_s;

	typedef struct packed {
		mdm_state_e     st;
		logic [2:0]     stn;
		logic [3:0]     byt;
		mdm_link_req_s  link;
		logic           active;
		logic           setup_err;
		logic           scan_err;
		logic           wdt_flag;
		logic           run;
		logic           clr;
		logic           ack;
		logic [31:0]    dat;
	} mdm_state_s;

endpackage : mdm_pkg

// ---- logic/mdm_wdog.sv ----
/*
 * Watchdog counter of the multidrop master.
 * Assumes arm_i stays high only while an answer from a slave is awaited.
 */
`timescale 1ns/1ps
module mdm_wdog #(
	parameter int CYCLES = mdm_pkg::MDM_WDT_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic arm_i,
	output logic      expire_o
);
	import mdm_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          exp;
	} mdm_wdog_state_s;

	mdm_wdog_state_s q;
	mdm_wdog_state_s d;

	always_comb begin
		d = q;
		d.exp = 1'b0;
		if (!arm_i) begin
			d.cnt = '0;
		end else if (q.cnt == LAST) begin
			// One pulse, then restart the count
			d.exp = 1'b1;
			d.cnt = '0;
		end else begin
			d.cnt = q.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign expire_o = q.exp;

endmodule : mdm_wdog

// ---- sim/mdm_slave_model.sv ----
/*
 * Behavioural set of slave stations on the far side of the master's link.
 * Assumes the request stays stable until the one-cycle ack is taken.
 */
`timescale 1ns/1ps
module mdm_slave_model (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire mdm_pkg::mdm_link_req_s link_req_i,
	output mdm_pkg::mdm_link_rsp_s      link_rsp_o,
	input  wire logic [3:0]             delay_i,
	input  wire logic [7:0]             seed_i,
	input  wire logic                   err_setup_i,
	input  wire logic                   err_scan_i,
	input  wire logic                   mute_i
);
	import mdm_pkg::*;
	logic [3:0] cnt_q;
	logic       ack_q;
	logic       err_q;
	logic       byt_q;
	logic [7:0] rx_q;
	logic [7:0] seen_tx [16];
	assign link_rsp_o = '{ack: ack_q, err: err_q & ack_q, rx: rx_q};
	// Output points latch tx
	// Input points answer rx
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			cnt_q <= 4'h0;
			byt_q <= 1'b0;
			rx_q  <= 8'h00;
		end else if (link_req_i.req && !ack_q && !mute_i &&
				cnt_q >= delay_i) begin
			ack_q <= 1'b1;
			cnt_q <= 4'h0;
			err_q <= link_req_i.setup ? err_setup_i : err_scan_i;
			rx_q  <= seed_i ^ {link_req_i.station, byt_q, 4'ha};
			byt_q <= link_req_i.setup ? 1'b0 : ~byt_q;
			if (!link_req_i.setup) begin
				seen_tx[{link_req_i.station, byt_q}] <= link_req_i.tx;
			end
		end else begin
			ack_q <= 1'b0;
			cnt_q <= link_req_i.req ? cnt_q + 4'h1 : 4'h0;
			// Released line shows a changing pattern
			rx_q  <= ~rx_q;
		end
	end
endmodule : mdm_slave_model

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench of the multidrop master: buffer, flags, link scan.
 * Assumes the slave model above and a shortened watchdog count.
 */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin failures++; \
	$display("unexpected %s exp %0h seen %0h", n, e, s); end end
`define WAITF(s) for (t = 0; t < 500 && (s) !== 1'b1; t++) @(posedge clk_i)
module tb_top;
	import mdm_pkg::*;
	localparam int WDT = 50;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          wb_cyc = 1'b0;
	logic          wb_stb = 1'b0;
	logic          wb_we = 1'b0;
	logic [6:0]    wb_adr = 7'h00;
	logic [3:0]    wb_sel = 4'hf;
	logic [31:0]   wb_dat = 32'h0000_0000;
	logic [31:0]   wb_dat_o;
	logic          wb_ack_o;
	logic [3:0]    delay = 4'h0;
	logic [7:0]    seed = 8'h00;
	logic          err_setup = 1'b0;
	logic          err_scan = 1'b0;
	logic          mute = 1'b0;
	logic          ce = 1'b1;
	logic [7:0]    sv;
	logic          act_o, set_o, scn_o, wdf_o;
	mdm_link_req_s link_req;
	mdm_link_rsp_s link_rsp;
	logic [31:0]   rd_q;
	logic [31:0]   tx [16];
	logic [15:0]   lf = 16'h0002;
	int            failures = 0;
	int            n_checks = 0;
	int            i, t;
	always #10 clk_i = ~clk_i;
	mdm_master #(.WDT_CYCLES(WDT)) u_mdm_master (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_req_o(link_req),
		.link_rsp_i(link_rsp), .transfer_active_flag_o(act_o),
		.setup_error_flag_o(set_o), .scan_error_flag_o(scn_o),
		.watchdog_fault_flag_o(wdf_o));
	mdm_slave_model u_mdm_slave_model (.clk_i(clk_i), .rst_i(rst_i),
		.link_req_i(link_req), .link_rsp_o(link_rsp), .delay_i(delay),
		.seed_i(seed), .err_setup_i(err_setup), .err_scan_i(err_scan),
		.mute_i(mute));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	function automatic logic [31:0] exp_rx(input logic [7:0] s, input int w);
		return {24'h0, s ^ {w[3:0], 4'ha}};
	endfunction : exp_rx
	task automatic step();
		lf = lfsr(lf);
		delay <= lf[3:0];
	endtask : step
	task automatic wb(input logic w, input logic [6:0] a,
		input logic [31:0] d);
		int k;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_dat <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		if (k >= 50) failures++;
		rd_q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic end_test(input string name);
		$display("test %s done, failures so far %0d", name, failures);
	endtask : end_test
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (10000) @(posedge clk_i);
		failures++;
		tally_and_finish();
	end
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK("flags", 4'h0, {act_o, set_o, scn_o, wdf_o})
		wb(1'b0, MDM_STAT_IDX, 32'h0000_0000);
		`CHK("status", 32'h0000_0000, rd_q)
		wb(1'b1, MDM_CTRL_IDX, 32'h0000_ffff);
		wb(1'b0, MDM_CTRL_IDX, 32'h0000_0000);
		`CHK("ctrl low", 32'h0000_0000, rd_q)
		end_test("reset");
		for (i = 0; i < 16; i++) begin
			step();
			tx[i] = {lf, ~lf};
			wb(1'b1, MDM_TX_BASE + 7'(i), tx[i]);
			wb(1'b0, MDM_TX_BASE + 7'(i), 32'h0000_0000);
			`CHK("tx word", {24'h0, tx[i][7:0]}, rd_q)
		end
		wb_sel <= 4'he;
		wb(1'b1, MDM_TX_BASE, ~tx[0]);
		wb_sel <= 4'hf;
		wb(1'b0, MDM_TX_BASE, 32'h0000_0000);
		`CHK("sel refused", {24'h0, tx[0][7:0]}, rd_q)
		end_test("buffer");
		seed <= lf[7:0];
		wb(1'b1, MDM_CTRL_IDX, 32'h0001_0000);
		`CHK("setup active", 1'b0, act_o)
		`WAITF(act_o);
		`CHK("active", 1'b1, act_o)
		repeat (70) begin
			step();
			repeat (10) @(posedge clk_i);
		end
		`CHK("active held", 1'b1, act_o)
		// Silent link while frozen: the watchdog must not advance
		mute <= 1'b1;
		@(posedge clk_i);
		ce <= 1'b0;
		repeat (2 * WDT) @(posedge clk_i);
		`CHK("frozen", 2'b10, {act_o, wdf_o})
		ce   <= 1'b1;
		mute <= 1'b0;
		repeat (40) @(posedge clk_i);
		for (i = 0; i < 16; i++) begin
			sv = u_mdm_slave_model.seen_tx[i];
			`CHK("link tx", tx[i][7:0], sv)
			wb(1'b0, MDM_RX_BASE + 7'(i), 32'h0000_0000);
			`CHK("rx word", exp_rx(seed, i), rd_q)
		end
		end_test("scan");
		err_scan <= 1'b1;
		`WAITF(scn_o);
		`CHK("scan err", 3'b001, {act_o, set_o, scn_o})
		err_scan <= 1'b0;
		repeat (20) @(posedge clk_i);
		wb(1'b0, MDM_STAT_IDX, 32'h0000_0000);
		`CHK("scan sticky", 32'h0000_0004, rd_q)
		wb(1'b1, MDM_CTRL_IDX, 32'h0003_0000);
		wb(1'b0, MDM_CTRL_IDX, 32'h0000_0000);
		`CHK("ctrl rb", 32'h0003_0000, rd_q)
		wb(1'b1, MDM_CTRL_IDX, 32'h0000_0000);
		`CHK("scan clr", 1'b0, scn_o)
		repeat (3) @(posedge clk_i);
		`CHK("stopped", 1'b0, link_req.req)
		end_test("scan error");
		err_setup <= 1'b1;
		wb(1'b1, MDM_CTRL_IDX, 32'h0001_0000);
		`WAITF(set_o);
		`CHK("setup err", 3'b010, {act_o, set_o, scn_o})
		err_setup <= 1'b0;
		wb(1'b0, MDM_STAT_IDX, 32'h0000_0000);
		`CHK("setup sticky", 32'h0000_0002, rd_q)
		wb(1'b1, MDM_CTRL_IDX, 32'h0002_0000);
		wb(1'b1, MDM_CTRL_IDX, 32'h0000_0000);
		`CHK("setup clr", 1'b0, set_o)
		end_test("setup error");
		mute <= 1'b1;
		wb(1'b1, MDM_CTRL_IDX, 32'h0001_0000);
		`WAITF(wdf_o);
		`CHK("wdt time", 1'b1, t > WDT - 10 && t < WDT + 10)
		wb(1'b0, MDM_STAT_IDX, 32'h0000_0000);
		`CHK("wdt status", 32'h0000_2002, rd_q)
		mute <= 1'b0;
		wb(1'b1, MDM_CTRL_IDX, 32'h0002_0000);
		wb(1'b1, MDM_CTRL_IDX, 32'h0000_0000);
		`CHK("wdt kept", 2'b01, {set_o, wdf_o})
		end_test("watchdog");
		tally_and_finish();
	end
endmodule : tb_top
